// File: dbrs_defs.svh
// Addresses, field positions, reset values and sizes of the data bank and stack logic
`ifndef DBRS_DEFS_SVH
`define DBRS_DEFS_SVH

// ****************************************************************
// Register addresses in the peripheral bank
// ****************************************************************
`define DBRS_SP_ADDR       12'hf80
`define DBRS_SBS_ADDR      12'hf84

// ****************************************************************
// Reset values and field positions
// ****************************************************************
`define DBRS_SBS_RESET     4'h8
`define DBRS_SBS_MODE_BIT  3

// ****************************************************************
// Banks and sizes
// ****************************************************************
`define DBRS_BANK_LOW      4'h0
`define DBRS_BANK_PERIPH   4'hf
`define DBRS_RAM_WORDS     128
`define DBRS_FRAME_MAX     6
`define DBRS_PUSH_NIBS     4'h2
`define DBRS_MK1_CALL_NIBS 4'h4
`define DBRS_MK2_CALL_NIBS 4'h5
`define DBRS_INT_NIBS      4'h6

`endif

// File: dbrs_pkg.sv
// Types shared by the data bank, register file and stack logic
package dbrs_pkg;

  typedef enum logic [2:0] {
    DBRS_PUSH, DBRS_POP, DBRS_CALL, DBRS_RET, DBRS_INTR, DBRS_RETI
  } dbrs_stk_op_t;

  typedef enum logic [1:0] {DBRS_PTR_HL, DBRS_PTR_DE, DBRS_PTR_DL} dbrs_ptr_t;

  typedef enum logic [2:0] {
    DBRS_BIT_SET, DBRS_BIT_CLR, DBRS_BIT_NOT, DBRS_BIT_LOAD,
    DBRS_BIT_AND, DBRS_BIT_OR, DBRS_BIT_XOR
  } dbrs_bit_op_t;

  typedef struct packed {
    logic       bank_select_enable;
    logic [3:0] memory_bank_selector;
    logic       register_bank_enable_flag;
    logic [1:0] register_bank_number;
  } dbrs_bank_ctl_t;

  typedef struct packed {
    logic       service_level_high;
    logic       service_level_low;
    logic       bank_select_enable;
    logic       register_bank_enable_flag;
    logic       skip_state_two;
    logic       skip_state_one;
    logic       skip_state_zero;
  } dbrs_flags_t;

  typedef struct packed {
    logic       req;
    logic       we;
    logic       wide;
    logic       use_ptr;
    dbrs_ptr_t  ptr;
    logic       auto_periph;
    logic [7:0] imm;
    logic [7:0] wdata;
  } dbrs_mem_req_t;

  typedef struct packed {
    logic       req;
    logic       we;
    logic       wide;
    logic       alt;
    logic [2:0] idx;
    logic [7:0] wdata;
  } dbrs_reg_req_t;

  typedef struct packed {
    logic         req;
    dbrs_stk_op_t op;
    logic [11:0]  pc;
    logic [7:0]   pair;
    dbrs_flags_t  flags;
  } dbrs_stk_req_t;

endpackage : dbrs_pkg

// File: dbrs_core.sv
// Data bank selection, banked registers, accumulators and hardware stack
// Notes on behaviour
// - Bank enabled: bank comes from bank selector.
// - Bank disabled: bank 0 or 15 by auto_periph.
// - Offset from immediate byte or register pair.
// - Data memory is not cleared at reset.
// - Four banks of eight nibble registers.
// - Active bank is enable ANDed with number.
// - Nibble registers; pairs XA, HL, DE, BC.
// - DE, HL, DL pairs act as pointers.
// - Wide ops may use bank with bit0 flipped.
// - Register area also plain RAM.
// - A is nibble accumulator, XA wide accumulator.
// - Carry is the bit accumulator.
// - Stack pointer, bit 0 reads zero, at F80.
// - Stack lives in 000-07F of bank 0.
// - Decrement before write, increment after read.
// - Pointer and stack bank register read/write.
// - Pointer 00 puts first write at 07F.
// - Pointer undefined at reset, bank register 1000.
// - Legacy returns restore frame in set order.
// - Extended calls write five nibbles, interrupts six; both move the pointer by six.
// - Extended call/return save only bank enables.
// - Stack register bit 3 selects stack mode.
// - Register bank enable low forces bank 0.
`timescale 1ns/10ps
`include "dbrs_defs.svh"

module dbrs_core (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire dbrs_pkg::dbrs_bank_ctl_t bank_ctl,
  input  wire dbrs_pkg::dbrs_mem_req_t  mem_req,
  output logic                         mem_ack,
  output logic [7:0]                   mem_rdata,
  input  wire dbrs_pkg::dbrs_reg_req_t  reg_req,
  output logic                         reg_ack,
  output logic [7:0]                   reg_rdata,
  input  wire dbrs_pkg::dbrs_stk_req_t  stk_req,
  output logic                         stk_done,
  output logic [11:0]                  ret_pc,
  output logic [7:0]                   pop_pair,
  output dbrs_pkg::dbrs_flags_t         ret_flags,
  output logic                         ret_carry_valid,
  input  wire logic                    bit_req,
  input  wire dbrs_pkg::dbrs_bit_op_t   bit_op,
  input  wire logic                    bit_in,
  output logic                         carry_bit,
  output logic [1:0]                   active_register_bank,
  output logic [3:0]                   data_bank,
  output logic                         legacy_stack_mode,
  output logic [3:0]                   acc_nibble,
  output logic [7:0]                   wide_accumulator_pair
);
  import dbrs_pkg::*;

  // ****************************************************************
  // Address helpers
  // ****************************************************************
  // Stack addresses keep only seven bits, so 00 minus one lands on 07F
  function automatic logic [6:0] stk_idx(input logic [7:0] a);
    stk_idx = a[6:0];
  endfunction : stk_idx

  function automatic logic [6:0] pair_base(input logic [1:0] rb, input logic [1:0] p);
    pair_base = {2'b00, rb, p, 1'b0};
  endfunction : pair_base

  // ****************************************************************
  // State
  // ****************************************************************
  logic [3:0]  ram_q [`DBRS_RAM_WORDS];
  logic [3:0]  ram_d [`DBRS_RAM_WORDS];
  logic [6:0]  sp_q, sp_d;
  logic [3:0]  sbs_q, sbs_d;
  logic        carry_q, carry_d;
  logic        mem_ack_q, mem_ack_d, reg_ack_q, reg_ack_d, stk_done_q, stk_done_d;
  logic        retc_q, retc_d;
  logic [7:0]  mem_rdata_q, mem_rdata_d, reg_rdata_q, reg_rdata_d;
  logic [7:0]  pop_q, pop_d;
  logic [11:0] ret_pc_q, ret_pc_d;
  dbrs_flags_t ret_flags_q, ret_flags_d;

  // ****************************************************************
  // Bank resolution
  // ****************************************************************
  logic [1:0]  rb;
  logic [1:0]  rb_wide;
  logic [3:0]  bank;
  logic [7:0]  ptr_val;
  logic [7:0]  offs;
  logic [11:0] addr;
  logic [7:0]  sp8;
  logic        mk1;
  logic [6:0]  hl_b, de_b;

  always_comb begin
    rb      = bank_ctl.register_bank_enable_flag ? bank_ctl.register_bank_number : 2'b00;
    rb_wide = reg_req.alt ? {rb[1], ~rb[0]} : rb;
    hl_b    = pair_base(rb, 2'd1);
    de_b    = pair_base(rb, 2'd2);
    unique case (mem_req.ptr)
      DBRS_PTR_DE: ptr_val = {ram_q[de_b + 7'd1], ram_q[de_b]};
      DBRS_PTR_DL: ptr_val = {ram_q[de_b + 7'd1], ram_q[hl_b]};
      default:     ptr_val = {ram_q[hl_b + 7'd1], ram_q[hl_b]};
    endcase
    offs = mem_req.use_ptr ? ptr_val : mem_req.imm;
    if (bank_ctl.bank_select_enable) begin
      bank = bank_ctl.memory_bank_selector;
    end else begin
      bank = mem_req.auto_periph ? `DBRS_BANK_PERIPH : `DBRS_BANK_LOW;
    end
    addr = {bank, offs};
    sp8  = {sp_q, 1'b0};
    mk1  = sbs_q[`DBRS_SBS_MODE_BIT];
  end

  assign active_register_bank  = rb;
  assign data_bank             = bank;
  assign legacy_stack_mode     = mk1;
  assign acc_nibble            = ram_q[pair_base(rb, 2'd0)];
  assign wide_accumulator_pair = {ram_q[pair_base(rb, 2'd0) + 7'd1], ram_q[pair_base(rb, 2'd0)]};

  // ****************************************************************
  // Stack frame layout
  // ****************************************************************
  // Frame nibble k sits at base + k; the lowest nibble is the new pointer
  logic [3:0] frm [`DBRS_FRAME_MAX];
  logic [3:0] rd  [`DBRS_FRAME_MAX];
  logic [7:0] wbase;
  logic [3:0] wcnt;
  logic [7:0] sp_step;
  logic       stk_go, mem_go, reg_go;

  always_comb begin
    stk_go = stk_req.req;
    mem_go = mem_req.req && !stk_go;
    reg_go = reg_req.req && !stk_go && !mem_go;
    frm[0] = stk_req.pc[11:8];
    frm[1] = mk1 ? {stk_req.flags.bank_select_enable,
                    stk_req.flags.register_bank_enable_flag, 2'b00} : 4'h0;
    frm[2] = stk_req.pc[3:0];
    frm[3] = stk_req.pc[7:4];
    frm[4] = {stk_req.flags.service_level_high, stk_req.flags.service_level_low,
              stk_req.flags.bank_select_enable, stk_req.flags.register_bank_enable_flag};
    frm[5] = {carry_q, stk_req.flags.skip_state_two, stk_req.flags.skip_state_one,
              stk_req.flags.skip_state_zero};
    wcnt    = 4'h0;
    sp_step = 8'h00;
    unique case (stk_req.op)
      DBRS_PUSH: begin
        frm[0]  = stk_req.pair[3:0];
        frm[1]  = stk_req.pair[7:4];
        wcnt    = `DBRS_PUSH_NIBS;
        sp_step = 8'(`DBRS_PUSH_NIBS);
      end
      DBRS_CALL: begin
        // Extended calls keep only the two bank enables, upper nibble bits zero
        frm[4]  = {2'b00, stk_req.flags.bank_select_enable,
                   stk_req.flags.register_bank_enable_flag};
        wcnt    = mk1 ? `DBRS_MK1_CALL_NIBS : `DBRS_MK2_CALL_NIBS;
        sp_step = mk1 ? 8'(`DBRS_MK1_CALL_NIBS) : 8'(`DBRS_INT_NIBS);
      end
      DBRS_INTR: begin
        wcnt    = `DBRS_INT_NIBS;
        sp_step = 8'(`DBRS_INT_NIBS);
      end
      DBRS_POP:  sp_step = 8'(`DBRS_PUSH_NIBS);
      DBRS_RET:  sp_step = mk1 ? 8'(`DBRS_MK1_CALL_NIBS) : 8'(`DBRS_INT_NIBS);
      DBRS_RETI: sp_step = 8'(`DBRS_INT_NIBS);
      default:   sp_step = 8'h00;
    endcase
    wbase = 8'(sp8 - sp_step);
  end

  for (genvar k = 0; k < `DBRS_FRAME_MAX; k++) begin : g_rd
    assign rd[k] = ram_q[stk_idx(8'(sp8 + 8'(k)))];
  end

  // ****************************************************************
  // RAM and stack pointer
  // ****************************************************************
  // No reset here: data memory and pointer power up undefined
  always_comb begin
    ram_d = ram_q;
    sp_d  = sp_q;
    if (stk_go) begin
      for (int k = 0; k < `DBRS_FRAME_MAX; k++) begin
        if (4'(k) < wcnt) begin
          ram_d[stk_idx(8'(wbase + 8'(k)))] = frm[k];
        end
      end
      if (wcnt != 4'h0) begin
        sp_d = wbase[7:1];
      end else begin
        sp_d = 7'(({1'b0, sp8} + {1'b0, sp_step}) >> 1);
      end
    end else if (mem_go && mem_req.we) begin
      if (bank == `DBRS_BANK_LOW && !offs[7]) begin
        if (mem_req.wide) begin
          ram_d[{offs[6:1], 1'b0}] = mem_req.wdata[3:0];
          ram_d[{offs[6:1], 1'b1}] = mem_req.wdata[7:4];
        end else begin
          ram_d[offs[6:0]] = mem_req.wdata[3:0];
        end
      end else if (addr == `DBRS_SP_ADDR && mem_req.wide) begin
        sp_d = mem_req.wdata[7:1];
      end
    end else if (reg_go && reg_req.we) begin
      if (reg_req.wide) begin
        ram_d[pair_base(rb_wide, reg_req.idx[1:0])]         = reg_req.wdata[3:0];
        ram_d[pair_base(rb_wide, reg_req.idx[1:0]) + 7'd1]  = reg_req.wdata[7:4];
      end else begin
        ram_d[{2'b00, rb, reg_req.idx}] = reg_req.wdata[3:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    ram_q <= ram_d;
    sp_q  <= sp_d;
  end

  // ****************************************************************
  // Control registers and answers
  // ****************************************************************
  always_comb begin
    sbs_d       = sbs_q;
    carry_d     = carry_q;
    mem_ack_d   = mem_go;
    reg_ack_d   = reg_go;
    stk_done_d  = stk_go;
    retc_d      = 1'b0;
    mem_rdata_d = mem_rdata_q;
    reg_rdata_d = reg_rdata_q;
    pop_d       = pop_q;
    ret_pc_d    = ret_pc_q;
    ret_flags_d = ret_flags_q;
    if (bit_req) begin
      unique case (bit_op)
        DBRS_BIT_SET:  carry_d = 1'b1;
        DBRS_BIT_CLR:  carry_d = 1'b0;
        DBRS_BIT_NOT:  carry_d = ~carry_q;
        DBRS_BIT_LOAD: carry_d = bit_in;
        DBRS_BIT_AND:  carry_d = carry_q & bit_in;
        DBRS_BIT_OR:   carry_d = carry_q | bit_in;
        DBRS_BIT_XOR:  carry_d = carry_q ^ bit_in;
        default:       carry_d = carry_q;
      endcase
    end
    if (stk_go) begin
      unique case (stk_req.op)
        DBRS_POP: pop_d = {rd[1], rd[0]};
        DBRS_RET, DBRS_RETI: begin
          ret_pc_d    = {rd[0], rd[3], rd[2]};
          ret_flags_d = ret_flags_q;
          if (stk_req.op == DBRS_RETI) begin
            ret_flags_d = {rd[4], rd[5][2:0]};
            carry_d     = rd[5][3];
            retc_d      = 1'b1;
          end else if (mk1) begin
            ret_flags_d.bank_select_enable        = rd[1][3];
            ret_flags_d.register_bank_enable_flag = rd[1][2];
          end else begin
            ret_flags_d.bank_select_enable        = rd[4][1];
            ret_flags_d.register_bank_enable_flag = rd[4][0];
          end
        end
        default: pop_d = pop_q;
      endcase
    end else if (mem_go) begin
      if (bank == `DBRS_BANK_LOW && !offs[7]) begin
        mem_rdata_d = mem_req.wide ? {ram_q[{offs[6:1], 1'b1}], ram_q[{offs[6:1], 1'b0}]}
                                   : {4'h0, ram_q[offs[6:0]]};
      end else if (addr == `DBRS_SP_ADDR) begin
        mem_rdata_d = sp8;
      end else if (addr == `DBRS_SBS_ADDR) begin
        mem_rdata_d = {4'h0, sbs_q};
        if (mem_req.we && !mem_req.wide) begin
          sbs_d = mem_req.wdata[3:0];
        end
      end else begin
        mem_rdata_d = 8'h00;
      end
    end else if (reg_go) begin
      reg_rdata_d = reg_req.wide
                  ? {ram_q[pair_base(rb_wide, reg_req.idx[1:0]) + 7'd1],
                     ram_q[pair_base(rb_wide, reg_req.idx[1:0])]}
                  : {4'h0, ram_q[{2'b00, rb, reg_req.idx}]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sbs_q       <= `DBRS_SBS_RESET;
      carry_q     <= 1'b0;
      mem_ack_q   <= 1'b0;
      reg_ack_q   <= 1'b0;
      stk_done_q  <= 1'b0;
      retc_q      <= 1'b0;
      mem_rdata_q <= 8'h00;
      reg_rdata_q <= 8'h00;
      pop_q       <= 8'h00;
      ret_pc_q    <= 12'h000;
      ret_flags_q <= '0;
    end else begin
      sbs_q       <= sbs_d;
      carry_q     <= carry_d;
      mem_ack_q   <= mem_ack_d;
      reg_ack_q   <= reg_ack_d;
      stk_done_q  <= stk_done_d;
      retc_q      <= retc_d;
      mem_rdata_q <= mem_rdata_d;
      reg_rdata_q <= reg_rdata_d;
      pop_q       <= pop_d;
      ret_pc_q    <= ret_pc_d;
      ret_flags_q <= ret_flags_d;
    end
  end

  assign mem_ack         = mem_ack_q;
  assign mem_rdata       = mem_rdata_q;
  assign reg_ack         = reg_ack_q;
  assign reg_rdata       = reg_rdata_q;
  assign stk_done        = stk_done_q;
  assign pop_pair        = pop_q;
  assign ret_pc          = ret_pc_q;
  assign ret_flags       = ret_flags_q;
  assign ret_carry_valid = retc_q;
  assign carry_bit       = carry_q;

endmodule : dbrs_core

// File: dbrs_core_sva.sv
// Port-level checks for the data bank, register file and stack core
`timescale 1ns/10ps
module dbrs_core_sva (
  input wire logic                     clk,
  input wire logic                     rst_n,
  input wire dbrs_pkg::dbrs_bank_ctl_t bank_ctl,
  input wire dbrs_pkg::dbrs_mem_req_t  mem_req,
  input wire logic                     mem_ack,
  input wire dbrs_pkg::dbrs_reg_req_t  reg_req,
  input wire logic                     reg_ack,
  input wire dbrs_pkg::dbrs_stk_req_t  stk_req,
  input wire logic                     stk_done,
  input wire logic                     ret_carry_valid,
  input wire logic                     bit_req,
  input wire dbrs_pkg::dbrs_bit_op_t   bit_op,
  input wire logic                     carry_bit,
  input wire logic [1:0]               active_register_bank,
  input wire logic [3:0]               data_bank,
  input wire logic                     legacy_stack_mode
);
  import dbrs_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ****
  // Bank selection
  // ****
  a_bank_select: assert property (bank_ctl.bank_select_enable |->
    data_bank == bank_ctl.memory_bank_selector) else $error("bank select mismatch");
  a_bank_auto: assert property (!bank_ctl.bank_select_enable |->
    data_bank == (mem_req.auto_periph ? 4'hf : 4'h0)) else $error("auto bank mismatch");
  a_rb_active: assert property (bank_ctl.register_bank_enable_flag |->
    active_register_bank == bank_ctl.register_bank_number) else $error("active bank wrong");
  a_rb_forced: assert property (!bank_ctl.register_bank_enable_flag |->
    active_register_bank == 2'b00) else $error("register bank not forced to 0");
  // ****
  // Access answers, carry and stack mode
  // ****
  a_mem_answer: assert property (mem_req.req && !stk_req.req |=> mem_ack)
    else $error("memory access not answered");
  a_mem_cause: assert property (mem_ack |-> $past(mem_req.req) && !$past(stk_req.req))
    else $error("memory answer without request");
  a_reg_refused: assert property (reg_req.req && (mem_req.req || stk_req.req)
    |=> !reg_ack) else $error("register access taken during conflict");
  a_stk_answer: assert property (stk_req.req |=> stk_done)
    else $error("stack operation not answered");
  a_reti_carry: assert property (stk_req.req && stk_req.op == DBRS_RETI
    |=> ret_carry_valid) else $error("carry restore missing");
  a_carry_set: assert property (bit_req && bit_op == DBRS_BIT_SET &&
    !(stk_req.req && stk_req.op == DBRS_RETI) |=> carry_bit) else $error("carry not set");
  a_mode_write: assert property (mem_req.req && mem_req.we && !mem_req.wide &&
    !stk_req.req && bank_ctl.bank_select_enable && bank_ctl.memory_bank_selector == 4'hf &&
    !mem_req.use_ptr && mem_req.imm == 8'h84 |=> legacy_stack_mode == $past(mem_req.wdata[3]))
    else $error("stack mode not taken from write");
  a_mode_reset: assert property ($rose(rst_n) |-> legacy_stack_mode)
    else $error("legacy mode not in force after reset");
endmodule : dbrs_core_sva

bind dbrs_core dbrs_core_sva chk_u (.clk(clk), .rst_n(rst_n), .bank_ctl(bank_ctl),
  .mem_req(mem_req), .mem_ack(mem_ack), .reg_req(reg_req), .reg_ack(reg_ack),
  .stk_req(stk_req), .stk_done(stk_done), .ret_carry_valid(ret_carry_valid),
  .bit_req(bit_req), .bit_op(bit_op), .carry_bit(carry_bit),
  .active_register_bank(active_register_bank), .data_bank(data_bank),
  .legacy_stack_mode(legacy_stack_mode));

// File: dbrs_core_tb_top.sv
// Directed bench for the data bank, register file and stack core
`timescale 1ns/10ps
module dbrs_core_tb_top;
  import dbrs_pkg::*;
  logic           clk, rst_n, bit_req, bit_in, mem_ack, reg_ack, stk_done;
  logic           ret_carry_valid, carry_bit, legacy_stack_mode, rcv, e;
  dbrs_bank_ctl_t bank_ctl;
  dbrs_mem_req_t  mem_req;
  dbrs_reg_req_t  reg_req;
  dbrs_stk_req_t  stk_req;
  dbrs_bit_op_t   bit_op;
  dbrs_flags_t    ret_flags;
  logic [7:0]     mem_rdata, reg_rdata, pop_pair, wide_accumulator_pair, r;
  logic [11:0]    ret_pc;
  logic [1:0]     active_register_bank;
  logic [3:0]     data_bank, acc_nibble;
  logic [3:0]     sel [3] = '{4'h0, 4'h4, 4'hf};
  int             error_cnt, total_checks, cyc;

  dbrs_core dut_u (.clk, .rst_n, .bank_ctl, .mem_req, .mem_ack, .mem_rdata, .reg_req,
    .reg_ack, .reg_rdata, .stk_req, .stk_done, .ret_pc, .pop_pair, .ret_flags,
    .ret_carry_valid, .bit_req, .bit_op, .bit_in, .carry_bit, .active_register_bank,
    .data_bank, .legacy_stack_mode, .acc_nibble, .wide_accumulator_pair);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic step;
    @(posedge clk);
    #1;
  endtask : step
  task automatic chk(input string n, input logic [11:0] x, input logic [11:0] g);
    total_checks++;
    if (g !== x) begin
      $display("[FAIL] %s expected %h seen %h", n, x, g);
      error_cnt++;
    end
  endtask : chk
  // Requests are raised one edge after the previous one dropped, so no signal
  // is assigned twice in a time step
  task automatic mem(input logic w, input logic wd, input logic up, input dbrs_ptr_t p,
                     input logic [3:0] b, input logic [7:0] a, input logic [7:0] d);
    step;
    bank_ctl.bank_select_enable = 1'b1;
    bank_ctl.memory_bank_selector = b;
    mem_req = '{1'b1, w, wd, up, p, 1'b0, a, d};
    step;
    mem_req.req = 1'b0;
    chk("mem_ack", 12'h1, mem_ack);
    r = mem_rdata;
  endtask : mem
  task automatic rg(input logic w, input logic wd, input logic alt, input logic [2:0] i,
                    input logic [7:0] d);
    step;
    reg_req = '{1'b1, w, wd, alt, i, d};
    step;
    reg_req.req = 1'b0;
    chk("reg_ack", 12'h1, reg_ack);
    r = reg_rdata;
  endtask : rg
  task automatic stk(input dbrs_stk_op_t o, input logic [11:0] pc, input logic [7:0] pr,
                     input dbrs_flags_t f);
    step;
    stk_req = '{1'b1, o, pc, pr, f};
    step;
    stk_req.req = 1'b0;
    chk("stk_done", 12'h1, stk_done);
    rcv = ret_carry_valid;
  endtask : stk
  task automatic bitop(input dbrs_bit_op_t o, input logic b);
    step;
    bit_req = 1'b1;
    bit_op = o;
    bit_in = b;
    step;
    bit_req = 1'b0;
  endtask : bitop
  task automatic rn(input logic [7:0] a, input logic [3:0] x);
    mem(1'b0, 1'b0, 1'b0, DBRS_PTR_HL, 4'h0, a, 8'h00);
    chk("ram", {8'h00, x}, {4'h0, r});
  endtask : rn
  task automatic fr(input logic [7:0] a, input logic [15:0] x);
    for (int k = 0; k < 4; k++) begin
      rn(a + 8'(k), x[4*k +: 4]);
    end
  endtask : fr
  task automatic sp(input logic [7:0] x);
    mem(1'b0, 1'b1, 1'b0, DBRS_PTR_HL, 4'hf, 8'h80, 8'h00);
    chk("sp", {4'h0, x}, {4'h0, r});
  endtask : sp
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  // Ceiling is about twenty times the roughly 146 cycles the sequence needs
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc == 3000) begin
        error_cnt++;
        $display("timeout");
        close_out();
      end
    end
  end

  initial begin
    {bank_ctl, mem_req, reg_req, stk_req} = '0;
    {bit_req, bit_in, rst_n, error_cnt, total_checks} = '0;
    bit_op = DBRS_BIT_SET;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    chk("mode", 12'h1, legacy_stack_mode);
    mem(1'b0, 1'b0, 1'b0, DBRS_PTR_HL, 4'hf, 8'h84, 8'h00);
    chk("sbs", 12'h8, r);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      step;
      bank_ctl.memory_bank_selector = sel[i];
      #1 chk("data_bank", sel[i], data_bank);
    end
    for (int i = 0; i < 2; i++) begin
      step;
      bank_ctl.bank_select_enable = 1'b0;
      mem_req.auto_periph = i[0];
      #1 chk("auto_bank", i[0] ? 12'hf : 12'h0, data_bank);
    end
    mem(1'b0, 1'b0, 1'b0, DBRS_PTR_HL, 4'h4, 8'h00, 8'h00);
    chk("unmapped", 12'h0, r);
    $display("test banks done");
    for (int i = 0; i < 4; i++) begin
      step;
      bank_ctl.register_bank_enable_flag = 1'b1;
      bank_ctl.register_bank_number = i[1:0];
      #1 chk("rb", i[1:0], active_register_bank);
      rg(1'b1, 1'b1, 1'b0, 3'h0, 8'(17 * i + 3));
      chk("xa", 8'(17 * i + 3), wide_accumulator_pair);
      rn(8'(8 * i), 4'(i + 3));
    end
    rg(1'b0, 1'b1, 1'b1, 3'h0, 8'h00);
    chk("alt_pair", 12'h25, r);
    step;
    bank_ctl.register_bank_enable_flag = 1'b0;
    #1 chk("rb_off", 12'h0, active_register_bank);
    chk("acc", 12'h3, acc_nibble);
    rg(1'b1, 1'b1, 1'b0, 3'h1, 8'h30);
    rg(1'b1, 1'b1, 1'b0, 3'h2, 8'h51);
    mem(1'b1, 1'b0, 1'b0, DBRS_PTR_HL, 4'h0, 8'h30, 8'h01);
    mem(1'b1, 1'b1, 1'b0, DBRS_PTR_HL, 4'h0, 8'h50, 8'h32);
    mem(1'b0, 1'b0, 1'b1, DBRS_PTR_HL, 4'h0, 8'h00, 8'h00);
    chk("ptr_main", 12'h1, r);
    mem(1'b0, 1'b0, 1'b1, DBRS_PTR_DE, 4'h0, 8'h00, 8'h00);
    chk("ptr_second", 12'h3, r);
    mem(1'b0, 1'b0, 1'b1, DBRS_PTR_DL, 4'h0, 8'h00, 8'h00);
    chk("ptr_mixed", 12'h2, r);
    step;
    mem_req = '{1'b1, 1'b0, 1'b0, 1'b0, DBRS_PTR_HL, 1'b0, 8'h00, 8'h00};
    reg_req.req = 1'b1;
    step;
    mem_req.req = 1'b0;
    reg_req.req = 1'b0;
    chk("reg_refused", 12'h0, reg_ack);
    chk("mem_taken", 12'h1, mem_ack);
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      bitop(dbrs_bit_op_t'(i), i[0]);
      case (i)
        0: e = 1'b1;
        1: e = 1'b0;
        2: e = ~e;
        3: e = i[0];
        4: e = e & i[0];
        5: e = e | i[0];
        default: e = e ^ i[0];
      endcase
      chk("carry", {11'h0, e}, carry_bit);
    end
    $display("test carry done");
    mem(1'b1, 1'b1, 1'b0, DBRS_PTR_HL, 4'hf, 8'h80, 8'h01);
    sp(8'h00);
    bank_ctl.memory_bank_selector = 4'h4;
    stk(DBRS_PUSH, 12'h000, 8'h3c, 7'h00);
    rn(8'h7f, 4'h3);
    rn(8'h7e, 4'hc);
    sp(8'hfe);
    stk(DBRS_CALL, 12'habc, 8'h00, 7'b0010000);
    fr(8'h7a, 16'hbc8a);
    stk(DBRS_RET, 12'h000, 8'h00, 7'h00);
    chk("ret_pc", 12'habc, ret_pc);
    chk("ret_flags", 12'h10, ret_flags);
    sp(8'hfe);
    stk(DBRS_POP, 12'h000, 8'h00, 7'h00);
    chk("pop_pair", 12'h3c, pop_pair);
    sp(8'h00);
    bitop(DBRS_BIT_SET, 1'b0);
    stk(DBRS_INTR, 12'h5a6, 8'h00, 7'b1011101);
    sp(8'hfa);
    rn(8'h7e, 4'hb);
    rn(8'h7f, 4'hd);
    bitop(DBRS_BIT_CLR, 1'b0);
    stk(DBRS_RETI, 12'h000, 8'h00, 7'h00);
    chk("carry_valid", 12'h1, rcv);
    chk("carry_back", 12'h1, carry_bit);
    chk("ret_pc", 12'h5a6, ret_pc);
    chk("ret_flags", 12'h5d, ret_flags);
    mem(1'b1, 1'b0, 1'b0, DBRS_PTR_HL, 4'hf, 8'h84, 8'h00);
    chk("mode", 12'h0, legacy_stack_mode);
    stk(DBRS_CALL, 12'h123, 8'h00, 7'b0001000);
    sp(8'hfa);
    fr(8'h7a, 16'h2301);
    rn(8'h7e, 4'h1);
    stk(DBRS_RET, 12'h000, 8'h00, 7'h00);
    chk("ret_pc", 12'h123, ret_pc);
    chk("ret_flags", 12'h4d, ret_flags);
    sp(8'h00);
    $display("test stack done");
    close_out();
  end
endmodule : dbrs_core_tb_top
